// >>> srt_consts.vh
// Constants for the status register transfer decoder
`ifndef SRT_CONSTS_VH
`define SRT_CONSTS_VH

// ----------------------------------------------------------------
// Instruction field positions
// ----------------------------------------------------------------
`define SRT_COND_HI 31
`define SRT_COND_LO 28
`define SRT_CLASS_HI 27
`define SRT_CLASS_LO 23
`define SRT_SEL_BIT 22
`define SRT_IMM_BIT 25
`define SRT_RD_HI 15
`define SRT_RD_LO 12
`define SRT_SRC_HI 3
`define SRT_SRC_LO 0
`define SRT_IMM8_HI 7
`define SRT_IMM8_LO 0
`define SRT_ROT_HI 11
`define SRT_ROT_LO 8
`define SRT_CLS2_HI 27
`define SRT_CLS2_LO 26
`define SRT_OPC_HI 24
`define SRT_OPC_LO 23

// ----------------------------------------------------------------
// Instruction encodings
// ----------------------------------------------------------------
`define SRT_CLASS_VAL 5'h02
`define SRT_CLS2_VAL 2'h0
`define SRT_OPC_VAL 2'h2
`define SRT_RD_PAT 6'h0f
`define SRT_RD_PAT_HI 21
`define SRT_RD_PAT_LO 16
`define SRT_LOW12_ZERO 12'h000
`define SRT_WR_PAT_HI 21
`define SRT_WR_PAT_LO 12
`define SRT_WR_FULL_PAT 10'h29f
`define SRT_WR_FLAG_PAT 10'h28f
`define SRT_MID8_HI 11
`define SRT_MID8_LO 4
`define SRT_MID8_ZERO 8'h00
`define SRT_PC_IDX 4'hf

// ----------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------
`define SRT_FLAG_HI 31
`define SRT_FLAG_LO 28
`define SRT_N_BIT 31
`define SRT_Z_BIT 30
`define SRT_C_BIT 29
`define SRT_V_BIT 28
`define SRT_CTRL_HI 7
`define SRT_CTRL_LO 0
`define SRT_MODE_HI 4
`define SRT_MODE_LO 0
`define SRT_FLAG_MASK 32'hf0000000
`define SRT_STATUS_RST 32'h000000d3

// ----------------------------------------------------------------
// Processor modes
// ----------------------------------------------------------------
`define SRT_MODE_USR 5'h10
`define SRT_MODE_FIQ 5'h11
`define SRT_MODE_IRQ 5'h12
`define SRT_MODE_SVC 5'h13
`define SRT_MODE_ABT 5'h17
`define SRT_MODE_UND 5'h1b
`define SRT_MODE_SYS 5'h1f

// ----------------------------------------------------------------
// Condition codes
// ----------------------------------------------------------------
`define SRT_CC_EQ 4'h0
`define SRT_CC_NE 4'h1
`define SRT_CC_CS 4'h2
`define SRT_CC_CC 4'h3
`define SRT_CC_MI 4'h4
`define SRT_CC_PL 4'h5
`define SRT_CC_VS 4'h6
`define SRT_CC_VC 4'h7
`define SRT_CC_HI 4'h8
`define SRT_CC_LS 4'h9
`define SRT_CC_GE 4'ha
`define SRT_CC_LT 4'hb
`define SRT_CC_GT 4'hc
`define SRT_CC_LE 4'hd
`define SRT_CC_AL 4'he

`endif

// >>> srt_cond_eval.v
// Condition field evaluator against the current flags
`timescale 1ns/100ps
`include "srt_consts.vh"

module srt_cond_eval (
   // Condition and flags
   input wire [3:0] cond_i,
   input wire [3:0] flags_i,
   // Result
   output reg pass_o
);

   // Individual flags
   wire n_w = flags_i[3];
   wire z_w = flags_i[2];
   wire c_w = flags_i[1];
   wire v_w = flags_i[0];

   // ----------------------------------------------------------------
   // Condition table
   // ----------------------------------------------------------------
   always @* begin
      case (cond_i)
         `SRT_CC_EQ: pass_o = z_w;
         `SRT_CC_NE: pass_o = ~z_w;
         `SRT_CC_CS: pass_o = c_w;
         `SRT_CC_CC: pass_o = ~c_w;
         `SRT_CC_MI: pass_o = n_w;
         `SRT_CC_PL: pass_o = ~n_w;
         `SRT_CC_VS: pass_o = v_w;
         `SRT_CC_VC: pass_o = ~v_w;
         `SRT_CC_HI: pass_o = c_w & ~z_w;
         `SRT_CC_LS: pass_o = ~c_w | z_w;
         `SRT_CC_GE: pass_o = (n_w == v_w);
         `SRT_CC_LT: pass_o = (n_w != v_w);
         `SRT_CC_GT: pass_o = ~z_w & (n_w == v_w);
         `SRT_CC_LE: pass_o = z_w | (n_w != v_w);
         `SRT_CC_AL: pass_o = 1'b1;
         // Reserved code never executes
         default: pass_o = 1'b0;
      endcase
   end

endmodule

// >>> srt_status_xfer.v
// Status register transfer decode and execute unit
//
// The implementer's own choices: the instruction-and-valid port and the placing of the registers.
`timescale 1ns/100ps
`include "srt_consts.vh"

module srt_status_xfer #(
   parameter DATA_W = 32
) (
   // Clock and reset
   input wire sys_clk_i,
   input wire rst_b_i,
   // Instruction stream
   input wire instr_valid_i,
   input wire [31:0] instr_i,
   input wire [DATA_W-1:0] source_gp_reg_i,
   // Core status load (exception entry, mode change)
   input wire status_load_i,
   input wire [DATA_W-1:0] status_load_data_i,
   // General register write-back
   output reg gp_wr_en_o,
   output reg [3:0] gp_wr_idx_o,
   output reg [DATA_W-1:0] gp_wr_data_o,
   // Execution outcome pulses
   output reg executed_o,
   output reg cond_fail_o,
   output reg ignored_o,
   output reg not_mine_o,
   // Status view
   output reg [DATA_W-1:0] current_status_reg_o,
   output reg [DATA_W-1:0] saved_status_reg_o
);

   // ----------------------------------------------------------------
   // Status storage
   // ----------------------------------------------------------------
   reg [DATA_W-1:0] cur_q; // Current status register
   reg [DATA_W-1:0] cur_d;
   reg [DATA_W-1:0] saved_fiq_q; // Saved status, fast interrupt
   reg [DATA_W-1:0] saved_irq_q; // Saved status, interrupt
   reg [DATA_W-1:0] saved_svc_q; // Saved status, supervisor
   reg [DATA_W-1:0] saved_abt_q; // Saved status, abort
   reg [DATA_W-1:0] saved_und_q; // Saved status, undefined
   reg [DATA_W-1:0] saved_d; // Next value of selected bank

   // ----------------------------------------------------------------
   // Instruction fields
   // ----------------------------------------------------------------
   wire [3:0] cond_w = instr_i[`SRT_COND_HI:`SRT_COND_LO];
   wire sel_saved_w = instr_i[`SRT_SEL_BIT];
   wire [3:0] rd_w = instr_i[`SRT_RD_HI:`SRT_RD_LO];
   wire [3:0] src_idx_w = instr_i[`SRT_SRC_HI:`SRT_SRC_LO];
   wire imm_sel_w = instr_i[`SRT_IMM_BIT];
   wire [4:0] mode_w = cur_q[`SRT_MODE_HI:`SRT_MODE_LO];
   wire [3:0] flags_w = cur_q[`SRT_FLAG_HI:`SRT_FLAG_LO];
   wire cond_pass_w;

   // Condition check against live flags
   srt_cond_eval u_cond (
      .cond_i(cond_w),
      .flags_i(flags_w),
      .pass_o(cond_pass_w)
   );

   // ----------------------------------------------------------------
   // Form recognition
   // ----------------------------------------------------------------
   // Read form: flagless compare/test opcode space
   wire is_read_w = (instr_i[`SRT_CLASS_HI:`SRT_CLASS_LO] == `SRT_CLASS_VAL) &&
      (instr_i[`SRT_RD_PAT_HI:`SRT_RD_PAT_LO] == `SRT_RD_PAT) &&
      (instr_i[`SRT_ROT_HI:`SRT_SRC_LO] == `SRT_LOW12_ZERO);
   // Full register write form
   wire is_wfull_w = (instr_i[`SRT_CLASS_HI:`SRT_CLASS_LO] == `SRT_CLASS_VAL) &&
      (instr_i[`SRT_WR_PAT_HI:`SRT_WR_PAT_LO] == `SRT_WR_FULL_PAT) &&
      (instr_i[`SRT_MID8_HI:`SRT_MID8_LO] == `SRT_MID8_ZERO);
   // Flag-only write form, register or immediate
   wire is_wflag_w = (instr_i[`SRT_CLS2_HI:`SRT_CLS2_LO] == `SRT_CLS2_VAL) &&
      (instr_i[`SRT_OPC_HI:`SRT_OPC_LO] == `SRT_OPC_VAL) &&
      (instr_i[`SRT_WR_PAT_HI:`SRT_WR_PAT_LO] == `SRT_WR_FLAG_PAT) &&
      (imm_sel_w || (instr_i[`SRT_MID8_HI:`SRT_MID8_LO] == `SRT_MID8_ZERO));
   wire is_mine_w = is_read_w | is_wfull_w | is_wflag_w;

   // ----------------------------------------------------------------
   // Immediate operand: 8 bits rotated right by twice rotate field
   // ----------------------------------------------------------------
   wire [DATA_W-1:0] imm8_w = {{(DATA_W-8){1'b0}}, instr_i[`SRT_IMM8_HI:`SRT_IMM8_LO]};
   wire [4:0] rot_w = {instr_i[`SRT_ROT_HI:`SRT_ROT_LO], 1'b0};
   wire [2*DATA_W-1:0] imm_dbl_w = {imm8_w, imm8_w} >> rot_w;
   wire [DATA_W-1:0] imm_val_w = imm_dbl_w[DATA_W-1:0];
   // Operand chosen by bit 25 in the flag-only form
   wire [DATA_W-1:0] src_val_w = (is_wflag_w && imm_sel_w) ? imm_val_w : source_gp_reg_i;

   // ----------------------------------------------------------------
   // Mode and bank selection
   // ----------------------------------------------------------------
   wire user_w = (mode_w == `SRT_MODE_USR);
   reg has_bank_w; // Current mode owns a saved register
   reg [DATA_W-1:0] saved_rd_w; // Saved register of current mode

   // Bank lookup by mode at execution time
   always @* begin
      has_bank_w = 1'b1;
      case (mode_w)
         `SRT_MODE_FIQ: saved_rd_w = saved_fiq_q;
         `SRT_MODE_IRQ: saved_rd_w = saved_irq_q;
         `SRT_MODE_SVC: saved_rd_w = saved_svc_q;
         `SRT_MODE_ABT: saved_rd_w = saved_abt_q;
         `SRT_MODE_UND: saved_rd_w = saved_und_q;
         // User, system and unknown modes have no bank
         default: begin
            saved_rd_w = {DATA_W{1'b0}};
            has_bank_w = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Execute decision
   // ----------------------------------------------------------------
   // Program counter as operand or missing bank is refused
   wire pc_bad_w = (is_read_w && (rd_w == `SRT_PC_IDX)) ||
      ((is_wfull_w || (is_wflag_w && !imm_sel_w)) && (src_idx_w == `SRT_PC_IDX));
   wire bank_bad_w = sel_saved_w && !has_bank_w;
   wire go_w = instr_valid_i && is_mine_w && cond_pass_w && !pc_bad_w && !bank_bad_w;
   // Field mask of the write: flags only or whole word
   wire [DATA_W-1:0] full_mask_w = {DATA_W{1'b1}};
   wire [DATA_W-1:0] flag_mask_w = `SRT_FLAG_MASK;
   reg [DATA_W-1:0] wmask_w;

   // Mask build, with user-mode protection of control bits
   always @* begin
      if (is_wflag_w) begin
         wmask_w = flag_mask_w;
      end else if (!sel_saved_w && user_w) begin
         wmask_w = flag_mask_w;
      end else begin
         wmask_w = full_mask_w;
      end
   end

   // ----------------------------------------------------------------
   // Next status values
   // ----------------------------------------------------------------
   always @* begin
      cur_d = cur_q;
      saved_d = saved_rd_w;
      if (go_w && (is_wfull_w || is_wflag_w)) begin
         if (sel_saved_w) begin
            saved_d = (saved_rd_w & ~wmask_w) | (src_val_w & wmask_w);
         end else begin
            cur_d = (cur_q & ~wmask_w) | (src_val_w & wmask_w);
         end
      end
      // Core load of the current register wins over a transfer
      if (status_load_i) begin
         cur_d = status_load_data_i;
      end
   end

   wire wr_saved_w = go_w && (is_wfull_w || is_wflag_w) && sel_saved_w;

   // ----------------------------------------------------------------
   // Status registers
   // ----------------------------------------------------------------
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cur_q <= `SRT_STATUS_RST;
         saved_fiq_q <= {DATA_W{1'b0}};
         saved_irq_q <= {DATA_W{1'b0}};
         saved_svc_q <= {DATA_W{1'b0}};
         saved_abt_q <= {DATA_W{1'b0}};
         saved_und_q <= {DATA_W{1'b0}};
      end else begin
         cur_q <= cur_d;
         // Only the bank of the executing mode is written
         if (wr_saved_w) begin
            case (mode_w)
               `SRT_MODE_FIQ: saved_fiq_q <= saved_d;
               `SRT_MODE_IRQ: saved_irq_q <= saved_d;
               `SRT_MODE_SVC: saved_svc_q <= saved_d;
               `SRT_MODE_ABT: saved_abt_q <= saved_d;
               `SRT_MODE_UND: saved_und_q <= saved_d;
               // No bank: nothing written
               default: begin
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Write-back and outcome outputs
   // ----------------------------------------------------------------
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gp_wr_en_o <= 1'b0;
         gp_wr_idx_o <= 4'h0;
         gp_wr_data_o <= {DATA_W{1'b0}};
         executed_o <= 1'b0;
         cond_fail_o <= 1'b0;
         ignored_o <= 1'b0;
         not_mine_o <= 1'b0;
         current_status_reg_o <= `SRT_STATUS_RST;
         saved_status_reg_o <= {DATA_W{1'b0}};
      end else begin
         gp_wr_en_o <= go_w && is_read_w;
         // Destination index and selected status value
         if (go_w && is_read_w) begin
            gp_wr_idx_o <= rd_w;
            gp_wr_data_o <= sel_saved_w ? saved_rd_w : cur_q;
         end
         executed_o <= go_w;
         cond_fail_o <= instr_valid_i && is_mine_w && !cond_pass_w;
         ignored_o <= instr_valid_i && is_mine_w && cond_pass_w &&
            (pc_bad_w || bank_bad_w);
         not_mine_o <= instr_valid_i && !is_mine_w;
         current_status_reg_o <= cur_d;
         saved_status_reg_o <= saved_rd_w;
      end
   end

endmodule

// >>> srt_chk.sv
// Port-level checker for the status register transfer unit
`timescale 1ns/100ps
module srt_chk #(
   parameter DATA_W = 32
) (
   // Clock, reset and stimulus
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire instr_valid_i,
   input wire [31:0] instr_i,
   input wire [DATA_W-1:0] source_gp_reg_i,
   input wire status_load_i,
   input wire [DATA_W-1:0] status_load_data_i,
   // Design outputs
   input wire gp_wr_en_o,
   input wire [3:0] gp_wr_idx_o,
   input wire [DATA_W-1:0] gp_wr_data_o,
   input wire executed_o,
   input wire cond_fail_o,
   input wire ignored_o,
   input wire not_mine_o,
   input wire [DATA_W-1:0] current_status_reg_o,
   input wire [DATA_W-1:0] saved_status_reg_o
);
   // -------------------------------------------------
   // Helpers
   // -------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Always-run read of current status, legal destination
   wire rd_cur = instr_valid_i && instr_i[31:16] == 16'he10f && instr_i[11:0] == 12'h000
      && instr_i[15:12] != 4'hf;
   // User mode seen on the status view
   wire in_usr = current_status_reg_o[4:0] == 5'h10;
   // -------------------------------------------------
   // Assertions
   // -------------------------------------------------
   chk_one_outcome: assert property (instr_valid_i |=>
      $onehot({executed_o, cond_fail_o, ignored_o, not_mine_o}))
      else $error("outcome not one-hot");
   chk_idle_quiet: assert property (!instr_valid_i |=>
      !(executed_o || cond_fail_o || ignored_o || not_mine_o)) else $error("pulse without instr");
   chk_read_value: assert property (rd_cur |=> gp_wr_en_o &&
      gp_wr_idx_o == $past(instr_i[15:12]) && gp_wr_data_o == $past(current_status_reg_o))
      else $error("read form wrong result");
   chk_flag_write: assert property (instr_valid_i && instr_i[31:12] == 20'he328f
      && !status_load_i |=> executed_o && $stable(current_status_reg_o[27:0]))
      else $error("flag write touched control bits");
   chk_user_ctrl: assert property (!status_load_i && in_usr |=>
      $stable(current_status_reg_o[27:0])) else $error("user mode control bits changed");
   chk_user_saved: assert property (instr_valid_i && instr_i[22] && in_usr |=>
      !executed_o && !gp_wr_en_o) else $error("saved access in user mode executed");
   chk_pc_dest: assert property (instr_valid_i && instr_i[21:12] == 10'h0ff |=>
      !gp_wr_en_o) else $error("read into program counter register");
   chk_flag_bit20: assert property (instr_valid_i && instr_i[20] |=> not_mine_o)
      else $error("flag-setting opcode taken as transfer");
   chk_cond_fail: assert property (cond_fail_o && !$past(status_load_i) |->
      $stable(current_status_reg_o) && !gp_wr_en_o) else $error("skipped instr had effect");
   chk_never_cond: assert property (instr_valid_i && instr_i[31:28] == 4'hf |=>
      !executed_o) else $error("never condition executed");
endmodule
bind srt_status_xfer srt_chk #(.DATA_W(DATA_W)) u_chk (.sys_clk_i, .rst_b_i, .instr_valid_i,
   .instr_i, .source_gp_reg_i, .status_load_i, .status_load_data_i, .gp_wr_en_o, .gp_wr_idx_o,
   .gp_wr_data_o, .executed_o, .cond_fail_o, .ignored_o, .not_mine_o, .current_status_reg_o,
   .saved_status_reg_o);

// >>> srt_gp_model.sv
// Model of the software register file feeding the source operand
`timescale 1ns/100ps
module srt_gp_model (
   // Register index from the instruction
   input wire [3:0] idx_i,
   // Register contents
   output logic [31:0] val_o
);
   // Flags = index, interrupts masked, mode code from index; index 15 reads 5a5a5a5a
   always_comb begin
      if (idx_i == 4'hf) begin
         val_o = 32'h5a5a5a5a;
      end else begin
         val_o = {idx_i, 20'h00000, 4'hd, idx_i};
      end
   end
endmodule

// >>> testbench.sv
// Testbench for the status register transfer unit
`timescale 1ns/100ps
module testbench;
   // Stimulus
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic instr_valid_i = 1'b0;
   logic [31:0] instr_i = 32'h00000000;
   logic status_load_i = 1'b0;
   logic [31:0] status_load_data_i = 32'h00000000;
   wire [31:0] source_gp_reg_i;
   // Design outputs
   wire gp_wr_en_o, executed_o, cond_fail_o, ignored_o, not_mine_o;
   wire [3:0] gp_wr_idx_o;
   wire [31:0] gp_wr_data_o, current_status_reg_o, saved_status_reg_o;
   wire [3:0] outc = {executed_o, cond_fail_o, ignored_o, not_mine_o};
   int fails = 0;
   int n_checks = 0;
   logic [3:0] fl [4] = '{4'h0, 4'hf, 4'h8, 4'h6};
   logic [3:0] md [5] = '{4'h1, 4'h2, 4'h3, 4'h7, 4'hb};
   srt_status_xfer #(.DATA_W(32)) uut (.sys_clk_i, .rst_b_i, .instr_valid_i, .instr_i,
      .source_gp_reg_i, .status_load_i, .status_load_data_i, .gp_wr_en_o, .gp_wr_idx_o,
      .gp_wr_data_o, .executed_o, .cond_fail_o, .ignored_o, .not_mine_o,
      .current_status_reg_o, .saved_status_reg_o);
   srt_gp_model u_gp (.idx_i(instr_i[3:0]), .val_o(source_gp_reg_i));
   // 250 MHz clock
   initial begin
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   // -------------------------------------------------
   // Tasks
   // -------------------------------------------------
   task automatic expect_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic expect_out(input logic [3:0] got, input logic [3:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: outcome %h expected %h", $time, got, exp);
      end
   endtask
   // One instruction; returns once its outcome has landed
   task automatic op(input logic [31:0] w);
      @(posedge sys_clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= w;
      @(posedge sys_clk_i);
      instr_valid_i <= 1'b0;
      #1;
   endtask
   // One-cycle core load of the current status; returns once it has landed
   task automatic load_st(input logic [31:0] v);
      @(posedge sys_clk_i);
      status_load_i <= 1'b1;
      status_load_data_i <= v;
      @(posedge sys_clk_i);
      status_load_i <= 1'b0;
      #1;
   endtask
   // Expected condition result; odd codes invert the even ones
   function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] q);
      logic n, z, cy, vv;
      {n, z, cy, vv} = q;
      case (c[3:1])
         3'h0: cond_ok = z;
         3'h1: cond_ok = cy;
         3'h2: cond_ok = n;
         3'h3: cond_ok = vv;
         3'h4: cond_ok = cy && !z;
         3'h5: cond_ok = n == vv;
         3'h6: cond_ok = !z && n == vv;
         default: cond_ok = 1'b1;
      endcase
      if (c[0]) cond_ok = !cond_ok;
   endfunction
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      fails++;
      results();
   end
   // -------------------------------------------------
   // Main sequence
   // -------------------------------------------------
   initial begin
      repeat (5) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      expect_word(current_status_reg_o, 32'h000000d3);
      expect_word(saved_status_reg_o, 32'h00000000);
      op(32'he10f3000);
      expect_out(outc, 4'h8);
      expect_word({31'h0, gp_wr_en_o}, 32'h00000001);
      expect_word({28'h0000000, gp_wr_idx_o}, 32'h00000003);
      expect_word(gp_wr_data_o, 32'h000000d3);
      $display("test reset and read done");
      // Every condition code against several flag sets
      foreach (fl[i]) begin
         op(32'he328f200 | fl[i]);
         expect_word(current_status_reg_o, {fl[i], 28'h00000d3});
         for (int c = 0; c < 16; c++) begin
            op({c[3:0], 28'h10f3000});
            expect_out(outc, cond_ok(c[3:0], fl[i]) ? 4'h8 : 4'h4);
         end
      end
      op(32'he128f003);
      expect_word(current_status_reg_o, 32'h300000d3);
      // Back to back: set zero flag, then equal-condition read
      @(posedge sys_clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= 32'he328f204;
      @(posedge sys_clk_i);
      instr_i <= 32'h010f3000;
      @(posedge sys_clk_i);
      instr_valid_i <= 1'b0;
      #1;
      expect_out(outc, 4'h8);
      $display("test conditions done");
      // Fill one saved bank per mode, then read each back
      foreach (md[i]) begin
         op(32'he129f000 | md[i]);
         expect_word(current_status_reg_o, {md[i], 20'h00000, 4'hd, md[i]});
         op(32'he169f000 | md[i]);
      end
      foreach (md[i]) begin
         op(32'he129f000 | md[i]);
         op(32'he14f2000);
         expect_word(gp_wr_data_o, {md[i], 20'h00000, 4'hd, md[i]});
         expect_word(saved_status_reg_o, {md[i], 20'h00000, 4'hd, md[i]});
      end
      $display("test banks done");
      // User mode: control bits held, saved access refused
      op(32'he129f000);
      op(32'he129f003);
      expect_word(current_status_reg_o, 32'h300000d0);
      op(32'he14f2000);
      expect_out(outc, 4'h2);
      op(32'he169f003);
      expect_out(outc, 4'h2);
      load_st(32'h000000d3);
      expect_word(current_status_reg_o, 32'h000000d3);
      // System mode: privileged, yet without a saved register
      load_st(32'h000000df);
      op(32'he14f2000);
      expect_out(outc, 4'h2);
      op(32'he129f003);
      expect_word(current_status_reg_o, 32'h300000d3);
      $display("test user and system mode done");
      // Program counter operands and foreign words
      op(32'he10ff000);
      expect_out(outc, 4'h2);
      expect_word({31'h0, gp_wr_en_o}, 32'h00000000);
      op(32'he129f00f);
      expect_out(outc, 4'h2);
      expect_word(current_status_reg_o, 32'h300000d3);
      op(32'he11f3000);
      expect_out(outc, 4'h1);
      op(32'he10f3001);
      expect_out(outc, 4'h1);
      $display("test refusals done");
      results();
   end
endmodule
